// *** lcd_fill_pkg.sv ***
// Purpose: Shared constants and types for the LCD display memory path
// Assumes: Avalon-MM byte addresses, 32-bit data words
// Notes:   Only byte lane 0 carries register fields
package lcd_fill_pkg;
   // ----------------------------------------------------------------
   // Geometry
   // ----------------------------------------------------------------
   localparam int NUM_WORDS = 80;
   localparam int NUM_ROWS  = 4;
   localparam int BYTE_BITS = 8;
   localparam int PTR_W     = 7;
   localparam int SUB_W     = 3;
   localparam int ADDR_W    = 5;
   localparam int DATA_W    = 32;
   localparam int BE_W      = 4;
   localparam int ALT_ROW   = 2;

   typedef enum logic [1:0] {
      MODE_STATIC,
      MODE_MUX2,
      MODE_MUX3,
      MODE_MUX4
   } mode_e;

   // ----------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------
   localparam logic [ADDR_W-1:0] OFS_CTRL     = 5'h00;
   localparam logic [ADDR_W-1:0] OFS_POINTER  = 5'h04;
   localparam logic [ADDR_W-1:0] OFS_SUBADDR  = 5'h08;
   localparam logic [ADDR_W-1:0] OFS_DATA     = 5'h0C;
   localparam logic [ADDR_W-1:0] OFS_STATUS   = 5'h10;
   localparam logic [ADDR_W-1:0] OFS_RAM_IDX  = 5'h14;
   localparam logic [ADDR_W-1:0] OFS_RAM_WORD = 5'h18;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_OUT_BANK = 2;
   localparam int CTRL_IN_BANK  = 3;
   localparam int CTRL_BLINK    = 4;
   localparam int STAT_MATCH    = 0;
   localparam int STAT_PHASE    = 1;
   localparam int STAT_STRAP    = 3;

   localparam logic [PTR_W-1:0] PTR_RESET = 7'h00;
   localparam logic [SUB_W-1:0] SUB_RESET = 3'h0;
endpackage

// *** backplane_select.sv ***
// Purpose: Maps the multiplex phase onto the four backplane lines
// Assumes: Phase never exceeds the row count of the mode
// Notes:   Purely combinational; caller registers the result
`timescale 1ns/1ps
`default_nettype none
module backplane_select (
   input  wire lcd_fill_pkg::mode_e mode,
   input  wire logic [1:0]          phase,
   output logic [3:0]               backplane
);
   import lcd_fill_pkg::*;

   // ----------------------------------------------------------------
   // Phase decode
   // ----------------------------------------------------------------
   always_comb begin
      backplane = 4'h0;
      case (mode)
         MODE_STATIC: begin
            backplane = 4'hF; // RL4
         end
         MODE_MUX2: begin
            backplane[0] = (phase == 2'h0); // RL5
            backplane[2] = (phase == 2'h0); // RL5
            backplane[1] = (phase == 2'h1); // RL5
            backplane[3] = (phase == 2'h1); // RL5
         end
         MODE_MUX3: begin
            backplane[0] = (phase == 2'h0);
            backplane[1] = (phase == 2'h1);
            backplane[2] = (phase == 2'h2);
            backplane[3] = (phase == 2'h1); // RL6
         end
         MODE_MUX4: begin
            backplane = 4'h1 << phase; // RL7
         end
         default: begin
            backplane = 4'h0;
         end
      endcase
   end
endmodule
`default_nettype wire

// *** lcd_ram_fill.sv ***
// Purpose: Display RAM, data pointer, sub-address match and bank select
// Assumes: phase_tick and blink_level come from frame and blink timing
// Notes:   One wait state on every bus access
//
// Overview of operation
// RL1: 80 by 4 RAM, one means on
// RL2: Word k drives segment k, row r backplane r
// RL3: Display register latches one row, all columns
// RL4: Static: all backplanes identical
// RL5: Two-way: backplane 2 follows 0, 3 follows 1
// RL6: Three-way: backplane 3 follows 1
// RL7: Four-way: every backplane distinct
// RL8: Display bytes stored immediately on arrival
// RL9: Static: eight words, row 0
// RL10: Two-way: four words, rows 0 and 1
// RL11: Three-way: three words, last slot untouched
// RL12: Four-way: two words, all rows
// RL13: Pointer load sets next store word
// RL14: Pointer steps 8, 4, 3 or 2
// RL15: Master reloads pointer after aborted transfer
// RL16: Store only when counter matches strap
// RL17: Device select loads sub-address counter
// RL18: Mismatch blocks store, pointer still steps
// RL19: Pointer overflow increments sub-address counter
// RL20: Output selector walks rows per mode
// RL21: Alternate bank shows rows 2 and 3
// RL22: Master keeps strap pins stable
// RL23: Input bank writes rows 2 and 3
// RL24: Bank blink swaps banks at blink rate
// RL25: Byte bits placed MSB first
// RL26: Pointer wraps past 79 to next device
`timescale 1ns/1ps
`default_nettype none
module lcd_ram_fill #(
   parameter int WORDS = lcd_fill_pkg::NUM_WORDS
) (
   input  wire logic                             clk,
   input  wire logic                             reset,
   input  wire logic [lcd_fill_pkg::ADDR_W-1:0]  address,
   input  wire logic                             read,
   input  wire logic                             write,
   input  wire logic [lcd_fill_pkg::BE_W-1:0]    byteenable,
   input  wire logic [lcd_fill_pkg::DATA_W-1:0]  writedata,
   output logic [lcd_fill_pkg::DATA_W-1:0]       readdata,
   output logic                                  waitrequest,
   input  wire logic                             hw_subaddr_bit0,
   input  wire logic                             hw_subaddr_bit1,
   input  wire logic                             hw_subaddr_bit2,
   input  wire logic                             phase_tick,
   input  wire logic                             blink_level,
   output logic [WORDS-1:0]                      segment_outputs,
   output logic                                  backplane_out_0,
   output logic                                  backplane_out_1,
   output logic                                  backplane_out_2,
   output logic                                  backplane_out_3
);
   import lcd_fill_pkg::*;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic int rows_of(input mode_e m);
      case (m)
         MODE_STATIC: rows_of = 1;
         MODE_MUX2:   rows_of = 2;
         MODE_MUX3:   rows_of = 3;
         default:     rows_of = 4;
      endcase
   endfunction

   // Words consumed by one byte, rounded up
   function automatic int step_of(input mode_e m);
      step_of = (BYTE_BITS + rows_of(m) - 1) / rows_of(m); // RL14
   endfunction

   function automatic logic bank_capable(input mode_e m);
      bank_capable = (m == MODE_STATIC) || (m == MODE_MUX2);
   endfunction

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   logic [3:0]       ram [WORDS]; // RL1
   logic [3:0]       next_ram [WORDS];
   mode_e            mode;
   mode_e            next_mode;
   logic             out_bank;
   logic             next_out_bank;
   logic             in_bank;
   logic             next_in_bank;
   logic             bank_blink;
   logic             next_bank_blink;
   logic [PTR_W-1:0] pointer;
   logic [PTR_W-1:0] next_pointer;
   logic [SUB_W-1:0] subaddr;
   logic [SUB_W-1:0] next_subaddr;
   logic [7:0]       last_byte;
   logic [7:0]       next_last_byte;
   logic [PTR_W-1:0] ram_idx;
   logic [PTR_W-1:0] next_ram_idx;
   logic [1:0]       phase;
   logic [1:0]       next_phase;
   logic [WORDS-1:0] disp_reg;
   logic [WORDS-1:0] next_disp_reg;
   logic [3:0]       bp;
   logic [3:0]       bp_comb;
   logic             ack;
   logic             next_ack;
   logic [DATA_W-1:0] rdata;
   logic [DATA_W-1:0] next_rdata;

   logic [SUB_W-1:0] strap;
   logic             match;
   logic             wr_go;
   logic             lane0;

   // Pins held stable by the master during access
   assign strap = {hw_subaddr_bit2, hw_subaddr_bit1, hw_subaddr_bit0}; // RL22
   assign match = (subaddr == strap);

   // ----------------------------------------------------------------
   // Bus handshake
   // ----------------------------------------------------------------
   // One wait state lets read data come from a flop
   assign waitrequest = (read | write) & ~ack;
   assign wr_go       = write & ack;
   assign lane0       = byteenable[0];

   always_comb begin
      next_ack   = (read | write) & ~ack;
      next_rdata = rdata;
      if ((read | write) & ~ack) begin
         next_rdata = '0;
         case (address)
            OFS_CTRL: begin
               next_rdata[CTRL_MODE_LSB +: 2] = mode;
               next_rdata[CTRL_OUT_BANK]      = out_bank;
               next_rdata[CTRL_IN_BANK]       = in_bank;
               next_rdata[CTRL_BLINK]         = bank_blink;
            end
            OFS_POINTER:  next_rdata[PTR_W-1:0] = pointer;
            OFS_SUBADDR:  next_rdata[SUB_W-1:0] = subaddr;
            OFS_DATA:     next_rdata[7:0]       = last_byte;
            OFS_STATUS: begin
               next_rdata[STAT_MATCH]        = match;
               next_rdata[STAT_PHASE +: 2]   = phase;
               next_rdata[STAT_STRAP +: 3]   = strap;
            end
            OFS_RAM_IDX:  next_rdata[PTR_W-1:0] = ram_idx;
            OFS_RAM_WORD: begin
               if (int'(ram_idx) < WORDS) begin
                  next_rdata[3:0] = ram[ram_idx];
               end
            end
            default:      next_rdata = '0;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         ack   <= 1'b0;
         rdata <= '0;
      end else begin
         ack   <= next_ack;
         rdata <= next_rdata;
      end
   end

   assign readdata = rdata;

   // ----------------------------------------------------------------
   // Control registers, pointer and sub-address counter
   // ----------------------------------------------------------------
   always_comb begin
      int sum;
      sum             = 0;
      next_mode       = mode;
      next_out_bank   = out_bank;
      next_in_bank    = in_bank;
      next_bank_blink = bank_blink;
      next_pointer    = pointer;
      next_subaddr    = subaddr;
      next_last_byte  = last_byte;
      next_ram_idx    = ram_idx;
      if (wr_go && lane0) begin
         case (address)
            OFS_CTRL: begin
               next_mode       = mode_e'(writedata[CTRL_MODE_LSB +: 2]);
               next_out_bank   = writedata[CTRL_OUT_BANK];
               next_in_bank    = writedata[CTRL_IN_BANK];
               next_bank_blink = writedata[CTRL_BLINK];
            end
            OFS_POINTER: begin
               next_pointer = writedata[PTR_W-1:0]; // RL13
            end
            OFS_SUBADDR: begin
               next_subaddr = writedata[SUB_W-1:0]; // RL17
            end
            OFS_DATA: begin
               next_last_byte = writedata[7:0];
               // Step regardless of match
               sum = int'(pointer) + step_of(mode); // RL14 RL18
               if (sum >= WORDS) begin
                  sum          = sum - WORDS; // RL26
                  next_subaddr = subaddr + 3'h1; // RL19
               end
               next_pointer = PTR_W'(sum);
            end
            OFS_RAM_IDX: begin
               next_ram_idx = writedata[PTR_W-1:0];
            end
            default: begin
               next_mode = mode;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         mode       <= MODE_STATIC;
         out_bank   <= 1'b0;
         in_bank    <= 1'b0;
         bank_blink <= 1'b0;
         pointer    <= PTR_RESET;
         subaddr    <= SUB_RESET;
         last_byte  <= 8'h00;
         ram_idx    <= PTR_RESET;
      end else begin
         mode       <= next_mode;
         out_bank   <= next_out_bank;
         in_bank    <= next_in_bank;
         bank_blink <= next_bank_blink;
         pointer    <= next_pointer;
         subaddr    <= next_subaddr;
         last_byte  <= next_last_byte;
         ram_idx    <= next_ram_idx;
      end
   end

   // ----------------------------------------------------------------
   // Display RAM fill
   // ----------------------------------------------------------------
   // Whole byte lands in one edge; bits past the last word belong
   // to the next device, so they wrap to word 0 and are stored only when subaddr + 1 matches the strap
   always_comb begin
      int rows;
      int word;
      int row;
      int roff;
      logic [SUB_W-1:0] sub;
      rows = rows_of(mode);
      word = 0;
      row  = 0;
      sub  = subaddr;
      roff = (in_bank && bank_capable(mode)) ? ALT_ROW : 0; // RL23
      for (int k = 0; k < WORDS; k++) begin
         next_ram[k] = ram[k];
      end
      if (wr_go && lane0 && address == OFS_DATA) begin // RL8
         for (int i = 0; i < BYTE_BITS; i++) begin
            word = int'(pointer) + i / rows; // RL9 RL10 RL11 RL12
            row  = i % rows + roff;
            sub  = subaddr;
            if (word >= WORDS) begin
               word = word - WORDS;
               sub  = subaddr + 3'h1; // RL19
            end
            if (sub == strap && word < WORDS) begin // RL16 RL18
               next_ram[word][row] = writedata[BYTE_BITS-1-i]; // RL25
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         for (int k = 0; k < WORDS; k++) begin
            ram[k] <= 4'h0;
         end
      end else begin
         for (int k = 0; k < WORDS; k++) begin
            ram[k] <= next_ram[k];
         end
      end
   end

   // ----------------------------------------------------------------
   // Output bank selector and display register
   // ----------------------------------------------------------------
   always_comb begin
      int sel;
      logic alt;
      sel        = 0;
      alt        = 1'b0;
      next_phase = phase;
      if (phase_tick) begin
         if (int'(phase) >= rows_of(mode) - 1) begin // RL20
            next_phase = 2'h0;
         end else begin
            next_phase = phase + 2'h1;
         end
      end
      // Blink swaps whichever bank is chosen
      alt = bank_capable(mode) && (out_bank ^ (bank_blink & blink_level)); // RL21 RL24
      sel = int'(next_phase) + (alt ? ALT_ROW : 0);
      next_disp_reg = disp_reg;
      if (phase_tick) begin
         for (int k = 0; k < WORDS; k++) begin
            next_disp_reg[k] = ram[k][sel]; // RL2 RL3
         end
      end
   end

   backplane_select u_bp (
      .mode      (mode),
      .phase     (phase),
      .backplane (bp_comb)
   );

   always_ff @(posedge clk) begin
      if (reset) begin
         phase    <= 2'h0;
         disp_reg <= '0;
         bp       <= 4'h0;
      end else begin
         phase    <= next_phase;
         disp_reg <= next_disp_reg;
         bp       <= bp_comb;
      end
   end

   assign segment_outputs = disp_reg;
   assign backplane_out_0 = bp[0];
   assign backplane_out_1 = bp[1];
   assign backplane_out_2 = bp[2];
   assign backplane_out_3 = bp[3];
endmodule
`default_nettype wire

// *** frame_timing_model.sv ***
// Purpose: Frame and blink timing source feeding the display path
// Assumes: tick_req is held high for at least one cycle per tick
// Notes:   Stands in for the frame divider, which lies outside the block
`timescale 1ns/1ps
`default_nettype none
module frame_timing_model (
   input  wire logic clk,
   input  wire logic reset,
   input  wire logic tick_req,
   input  wire logic blink_sel,
   output logic      phase_tick,
   output logic      blink_level
);
   logic req_q;
   // ----------------------------------------------------------------
   // Edge detect keeps every tick one cycle wide
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (reset) begin
         req_q       <= 1'b0;
         phase_tick  <= 1'b0;
         blink_level <= 1'b0;
      end else begin
         req_q       <= tick_req;
         phase_tick  <= tick_req & ~req_q;
         blink_level <= blink_sel;
      end
   end
endmodule
`default_nettype wire

// *** lcd_ram_fill_props.sv ***
// Purpose: Port-level assertions for the display memory path
// Assumes: Single clock domain, synchronous reset
// Notes:   Mode is not visible here, so backplanes are checked by pattern
`timescale 1ns/1ps
`default_nettype none
module lcd_ram_fill_props #(
   parameter int WORDS = 80
) (
   input wire logic              clk,
   input wire logic              reset,
   input wire logic              read,
   input wire logic              write,
   input wire logic              waitrequest,
   input wire logic [31:0]       readdata,
   input wire logic              phase_tick,
   input wire logic [WORDS-1:0]  segment_outputs,
   input wire logic              backplane_out_0,
   input wire logic              backplane_out_1,
   input wire logic              backplane_out_2,
   input wire logic              backplane_out_3
);
   wire logic [3:0] bp = {backplane_out_3, backplane_out_2, backplane_out_1, backplane_out_0};
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_first_wait: assert property ($rose(read || write) |-> waitrequest)
      else $error("request answered without wait state");
   a_one_wait: assert property ((read || write) && waitrequest |=> !waitrequest)
      else $error("more than one wait state");
   a_wait_req: assert property (waitrequest |-> (read || write))
      else $error("waitrequest without request");
   a_bp_legal: assert property (bp inside {4'h0, 4'hF, 4'h5, 4'hA, 4'h1, 4'h2, 4'h4, 4'h8})
      else $error("backplane pattern fits no drive mode");
   a_bp_start: assert property ($fell(reset) |=> bp == 4'hF)
      else $error("backplanes not all driven in static mode");
   a_seg_reset: assert property ($fell(reset) |-> segment_outputs == '0)
      else $error("segments not cleared by reset");
   a_seg_hold: assert property (!phase_tick |=> $stable(segment_outputs))
      else $error("display register changed without tick");
   a_rdata_hold: assert property (!(read || write) |=> $stable(readdata))
      else $error("read data changed while idle");
endmodule
bind lcd_ram_fill lcd_ram_fill_props #(.WORDS(WORDS)) props (.clk(clk), .reset(reset),
   .read(read), .write(write), .waitrequest(waitrequest), .readdata(readdata),
   .phase_tick(phase_tick), .segment_outputs(segment_outputs),
   .backplane_out_0(backplane_out_0), .backplane_out_1(backplane_out_1),
   .backplane_out_2(backplane_out_2), .backplane_out_3(backplane_out_3));
`default_nettype wire

// *** lcd_ram_fill_test.sv ***
// Purpose: Self-checking bench for the display memory path
// Assumes: Bus answers after one wait state
// Notes:   A shadow RAM predicts every stored bit and every display row
`timescale 1ns/1ps
`default_nettype none
module lcd_ram_fill_test;
   import lcd_fill_pkg::*;
   logic        clk = 1'b0;
   logic        reset = 1'b1;
   logic [4:0]  address = 5'h00;
   logic        read = 1'b0;
   logic        write = 1'b0;
   logic [3:0]  byteenable = 4'hF;
   logic [31:0] writedata = 32'h0;
   logic [31:0] readdata;
   logic        waitrequest;
   logic [2:0]  strap = 3'h0;
   logic        tick_req = 1'b0;
   logic        blink_sel = 1'b0;
   logic        phase_tick;
   logic        blink_level;
   logic [79:0] segment_outputs;
   wire logic [3:0] bp;
   logic [3:0]  shadow [80];
   logic [31:0] rd;
   logic [1:0]  ph = 2'h0;
   int          miscompares = 0;
   int          total_checks = 0;
   always #2 clk = ~clk;
   lcd_ram_fill #(.WORDS(NUM_WORDS)) uut (.clk(clk), .reset(reset), .address(address),
      .read(read), .write(write), .byteenable(byteenable), .writedata(writedata),
      .readdata(readdata), .waitrequest(waitrequest), .hw_subaddr_bit0(strap[0]),
      .hw_subaddr_bit1(strap[1]), .hw_subaddr_bit2(strap[2]), .phase_tick(phase_tick),
      .blink_level(blink_level), .segment_outputs(segment_outputs),
      .backplane_out_0(bp[0]), .backplane_out_1(bp[1]), .backplane_out_2(bp[2]),
      .backplane_out_3(bp[3]));
   frame_timing_model ftm (.clk(clk), .reset(reset), .tick_req(tick_req),
      .blink_sel(blink_sel), .phase_tick(phase_tick), .blink_level(blink_level));
   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [79:0] seen, exp);
      total_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Read right after an edge, so the values are those the slave saw there
   task automatic access(input logic is_rd, input logic [4:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      read <= is_rd;
      write <= !is_rd;
      address <= a;
      writedata <= d;
      for (n = 0; n < 16; n++) begin
         @(posedge clk);
         if (waitrequest === 1'b0) break;
      end
      if (n == 16) begin
         miscompares++;
         wrap_up();
      end
      rd = readdata;
      read <= 1'b0;
      write <= 1'b0;
   endtask
   task automatic rd_chk(input string what, input logic [4:0] a, input logic [31:0] e);
      access(1'b1, a, 32'h0);
      check(what, rd, e);
   endtask
   task automatic fill(input logic [1:0] m, input logic ib, input logic [2:0] st, sb,
                       input logic [6:0] p, input logic [7:0] b);
      int w, r, n, ep;
      logic [2:0] s, es;
      strap <= st;
      access(1'b0, OFS_CTRL, {28'h0, ib, 1'b0, m});
      access(1'b0, OFS_SUBADDR, {29'h0, sb});
      access(1'b0, OFS_POINTER, {25'h0, p});
      access(1'b0, OFS_DATA, {24'h0, b});
      n = m + 1;
      for (int j = 0; j < 8; j++) begin
         w = p + j / n;
         r = j % n + ((ib && m < 2) ? 2 : 0);
         s = sb;
         if (w >= 80) begin
            w -= 80;
            s = sb + 3'h1;
         end
         if (s == st) shadow[w][r] = b[7 - j];
      end
      ep = p + ((m == 0) ? 8 : (m == 1) ? 4 : (m == 2) ? 3 : 2);
      es = sb;
      if (ep >= 80) begin
         ep -= 80;
         es = sb + 3'h1;
      end
      rd_chk("pointer", OFS_POINTER, 32'(ep));
      rd_chk("subaddr", OFS_SUBADDR, {29'h0, es});
      access(1'b1, OFS_STATUS, 32'h0);
      check("status", {rd[5:3], rd[0]}, {st, es == st});
   endtask
   function automatic logic [3:0] bp_exp(input logic [1:0] m, p);
      case (m)
         2'd0: return 4'hF;
         2'd1: return p[0] ? 4'hA : 4'h5;
         2'd2: return (p == 2'd0) ? 4'h1 : (p == 2'd1) ? 4'hA : 4'h4;
         default: return 4'h1 << p;
      endcase
   endfunction
   task automatic show(input logic [1:0] m, input logic ob, be, bl);
      logic [79:0] e;
      int r;
      blink_sel <= bl;
      access(1'b0, OFS_CTRL, {27'h0, be, 1'b0, ob, m});
      @(posedge clk);
      tick_req <= 1'b1;
      @(posedge clk);
      tick_req <= 1'b0;
      repeat (3) @(posedge clk);
      ph = (ph >= m) ? 2'h0 : ph + 2'h1;
      access(1'b1, OFS_STATUS, 32'h0);
      check("phase", rd[2:1], ph);
      r = ph + ((m < 2 && (ob ^ (be & bl))) ? 2 : 0);
      for (int k = 0; k < 80; k++) e[k] = shadow[k][r];
      check("segments", segment_outputs, e);
      check("backplanes", {76'h0, bp}, {76'h0, bp_exp(m, ph)});
   endtask
   // ----------------------------------------------------------------
   // Sequence
   // ----------------------------------------------------------------
   initial begin
      foreach (shadow[k]) shadow[k] = 4'h0;
      repeat (8) @(posedge clk);
      reset <= 1'b0;
      rd_chk("ctrl", OFS_CTRL, 32'h0);
      rd_chk("pointer", OFS_POINTER, 32'h0);
      rd_chk("status", OFS_STATUS, 32'h1);
      access(1'b0, 5'h1C, 32'hFF);
      rd_chk("unmapped", 5'h1C, 32'h0);
      rd_chk("ctrl", OFS_CTRL, 32'h0);
      byteenable <= 4'hE;
      access(1'b0, OFS_CTRL, 32'h1F);
      byteenable <= 4'hF;
      rd_chk("ctrl lane", OFS_CTRL, 32'h0);
      $display("test reset done");
      fill(2'd0, 1'b0, 3'h0, 3'h0, 7'd0, 8'hA5);
      fill(2'd0, 1'b1, 3'h0, 3'h0, 7'd0, 8'h0F);
      fill(2'd1, 1'b0, 3'h0, 3'h0, 7'd20, 8'hC3);
      fill(2'd1, 1'b1, 3'h0, 3'h0, 7'd20, 8'h5A);
      fill(2'd3, 1'b0, 3'h0, 3'h0, 7'd60, 8'hFF);
      fill(2'd2, 1'b0, 3'h0, 3'h0, 7'd59, 8'h00);
      fill(2'd0, 1'b0, 3'h3, 3'h0, 7'd30, 8'hFF);
      fill(2'd3, 1'b0, 3'h3, 3'h2, 7'd79, 8'h3C);
      fill(2'd2, 1'b0, 3'h0, 3'h0, 7'd78, 8'h96);
      $display("test fill done");
      for (int k = 0; k < 80; k++) begin
         access(1'b0, OFS_RAM_IDX, 32'(k));
         rd_chk("ram word", OFS_RAM_WORD, {28'h0, shadow[k]});
      end
      $display("test ram done");
      show(2'd0, 1'b0, 1'b0, 1'b0);
      show(2'd0, 1'b1, 1'b0, 1'b0);
      show(2'd0, 1'b0, 1'b1, 1'b1);
      show(2'd1, 1'b1, 1'b1, 1'b1);
      show(2'd1, 1'b1, 1'b0, 1'b0);
      show(2'd1, 1'b1, 1'b0, 1'b0);
      show(2'd3, 1'b1, 1'b0, 1'b0);
      for (int m = 1; m < 4; m++) begin
         for (int k = 0; k <= m; k++) show(2'(m), 1'b0, 1'b0, 1'b0);
      end
      $display("test display done");
      wrap_up();
   end
endmodule
`default_nettype wire
